// >>> core/isp_flash_access_boot_key.sv
// How it works
// RULE1: A 1 KB boot ROM holds the factory programming routine.
// RULE2: Boot-select bit 0 at reset starts execution in boot ROM.
// RULE3: Boot-select bit 1 at reset starts fetching at flash 0000.
// RULE4: Programmer sets boot-select to 1 then resets to run flash.
// RULE5: Flash address is high byte over low byte, 16 bits.
// RULE6: Both address bytes clear to 00 on reset.
// RULE7: Software loads page start, 0000 or FFFF before erase or option read.
// RULE8: Address FFFF reaches the option register at 7FFF, even secured.
// RULE9: Software holds address, data and timing during an operation.
// RULE10: Read-data register captures flash read byte, readable anywhere.
// RULE11: Write-data register holds the byte to program.
// RULE12: Pulse-timing value sets internal write and erase pulse width.
// RULE13: Software picks timing code by oscillator band, 01 to 7B.
// RULE14: Pulse-timing resets to the 10 MHz code.
// RULE15: Internal control register is hidden from user code.
// RULE16: No fetch from user flash while it is being programmed.
// RULE17: Key write sets flag only when bits 7..2 equal 100110.
// RULE18: Key flag holds eight instruction cycles then clears.
// RULE19: Jump-to-boot enters boot ROM only while key flag set.
// RULE20: Without key, jump-to-boot branches to its flash target.
// RULE21: Return-to-flash moves execution from boot ROM to flash.
// RULE22: Emulation breakpoint freezes the key cycle counter.
// RULE23: Key counter runs during interrupts; disable them first.
// RULE24: A new matching key write restarts the eight-cycle window.
`timescale 1ns/1ns
module isp_flash_access_boot_key (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [2:0] reg_select_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic boot_select_bit_in,
	input wire logic jump_to_boot_instruction_in,
	input wire logic [15:0] jump_target_in,
	input wire logic return_to_flash_instruction_in,
	input wire logic [15:0] return_target_in,
	input wire logic emulation_break_in,
	input wire logic [1:0] flash_op_in,
	input wire logic flash_done_in,
	input wire logic [7:0] flash_rdata_in,
	input wire logic [9:0] boot_fetch_addr_in,
	output logic [7:0] reg_rdata_out,
	output logic [7:0] boot_rom_data_out,
	output logic exec_from_boot_out,
	output logic pc_load_out,
	output logic [15:0] pc_value_out,
	output logic [15:0] flash_address_out,
	output logic [7:0] flash_wdata_out,
	output logic [7:0] pulse_timing_out,
	output logic flash_busy_out,
	output logic fetch_blocked_out,
	output logic key_set_out
);
	import isp_access_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	// Software-visible registers come first.
	// The rest track flash operations, the start memory and the key window.
	logic [7:0] flash_address_high_reg, flash_address_high_next;
	logic [7:0] flash_address_low_reg, flash_address_low_next;
	logic [7:0] flash_read_data_reg, flash_read_data_next;
	logic [7:0] flash_write_data_reg, flash_write_data_next;
	logic [7:0] write_pulse_timing_reg, write_pulse_timing_next;
	logic [7:0] rdata_reg, rdata_next;
	logic boot_reg, boot_next;
	logic pc_load_reg, pc_load_next;
	logic [15:0] pc_value_reg, pc_value_next;
	logic busy_reg, busy_next;
	logic started_reg, started_next;
	flash_op_type op_reg, op_next;
	logic key_load;
	logic key_flag;
	logic [7:0] rom_data;
	logic key_freeze;
	logic [15:0] address_joined;
	logic [15:0] address_out_reg, address_out_next;
	logic blocked_reg, blocked_next;

	// ------------------------------------------------------------
	// Boot ROM
	// ------------------------------------------------------------
	// The store answers one clock after the fetch address is presented.
	// The core's fetch stage must allow for that cycle.
	// RULE1: 1 KB boot ROM
	boot_rom_store rom_inst (
		.core_clk_in(core_clk_in),
		.addr_in(boot_fetch_addr_in),
		.data_out(rom_data)
	);

	// ------------------------------------------------------------
	// Key window
	// ------------------------------------------------------------
	// RULE17: match bits 7..2 only
	assign key_load = reg_write_in && (reg_select_in == sel_unlock)
		&& (reg_wdata_in[unlock_hi:unlock_lo] == unlock_pattern);

	// RULE22: freeze only while key set
	assign key_freeze = emulation_break_in && key_flag;

	// The window counts core clocks, one per instruction cycle.
	// Interrupts do not stop it, so a key written before they are masked can expire unused.
	key_window_timer key_inst (
		.core_clk_in(core_clk_in),
		.resetn_in(resetn_in),
		.load_in(key_load),
		.freeze_in(key_freeze),
		.key_set_out(key_flag)
	);

	// ------------------------------------------------------------
	// Programming registers
	// ------------------------------------------------------------
	// Writes to the read-data and control selects fall to the default branch and change nothing.
	// The read answer is zero whenever no read is asked for, so the port idles at a known value.
	always_comb begin
		flash_address_high_next = flash_address_high_reg;
		flash_address_low_next = flash_address_low_reg;
		flash_write_data_next = flash_write_data_reg;
		write_pulse_timing_next = write_pulse_timing_reg;
		flash_read_data_next = flash_read_data_reg;
		rdata_next = 8'h00;
		if (reg_write_in) begin
			case (reg_select_in)
				sel_address_high: flash_address_high_next = reg_wdata_in;
				sel_address_low: flash_address_low_next = reg_wdata_in;
				// RULE11: byte to program
				sel_write_data: flash_write_data_next = reg_wdata_in;
				// RULE12: pulse width code, bit 7 read-only
				sel_pulse_timing: write_pulse_timing_next = reg_wdata_in & pulse_timing_mask;
				default: begin
				end
			endcase
		end
		// RULE10: capture read byte
		if (busy_reg && flash_done_in && (op_reg == op_read)) begin
			flash_read_data_next = flash_rdata_in;
		end
		// The answer is registered, so it stands for exactly one cycle after the request.
		if (reg_read_in) begin
			case (reg_select_in)
				sel_address_high: rdata_next = flash_address_high_reg;
				sel_address_low: rdata_next = flash_address_low_reg;
				sel_read_data: rdata_next = flash_read_data_reg;
				sel_write_data: rdata_next = flash_write_data_reg;
				sel_pulse_timing: rdata_next = write_pulse_timing_reg;
				// RULE15: control register hidden
				sel_control_internal: rdata_next = 8'h00;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			// RULE6: address bytes clear
			flash_address_high_reg <= address_reset;
			flash_address_low_reg <= address_reset;
			// RULE14: 10 MHz code
			write_pulse_timing_reg <= pulse_timing_reset;
			rdata_reg <= 8'h00;
		end else begin
			flash_address_high_reg <= flash_address_high_next;
			flash_address_low_reg <= flash_address_low_next;
			write_pulse_timing_reg <= write_pulse_timing_next;
			rdata_reg <= rdata_next;
		end
	end

	// Read and write data are undefined after reset, so they carry no reset term.
	always_ff @(posedge core_clk_in) begin
		flash_read_data_reg <= flash_read_data_next;
		flash_write_data_reg <= flash_write_data_next;
	end

	// ------------------------------------------------------------
	// Flash operation tracking
	// ------------------------------------------------------------
	// One operation is tracked at a time. A request that arrives while busy is dropped, not queued,
	// so the core must wait for busy to fall before it starts the next one.
	always_comb begin
		op_next = op_reg;
		busy_next = busy_reg;
		// Done ends the operation even when a new request waits; that request is dropped like any other that arrives while busy.
		if (busy_reg && flash_done_in) begin
			busy_next = 1'b0;
			op_next = op_idle;
		end else if (!busy_reg && (flash_op_in != 2'(op_idle))) begin
			busy_next = 1'b1;
			op_next = flash_op_type'(flash_op_in);
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			busy_reg <= 1'b0;
			op_reg <= op_idle;
		end else begin
			busy_reg <= busy_next;
			op_reg <= op_next;
		end
	end

	// ------------------------------------------------------------
	// Registered address and fetch guard
	// ------------------------------------------------------------
	// Both are built from next values, so they change on the same edge as the registers behind them.
	// This keeps the outputs registered without adding a cycle of delay.
	always_comb begin
		// RULE5: high over low
		address_joined = {flash_address_high_next, flash_address_low_next};
		address_out_next = address_joined;
		// RULE8: alias FFFF to option register
		if (address_joined == option_alias_address) begin
			address_out_next = option_real_address;
		end
		blocked_next = 1'b0;
		// RULE16: block flash fetch
		// Reads leave the array fetchable; only write and erase shut it.
		if (busy_next && (op_next != op_read)) begin
			blocked_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			address_out_reg <= {address_reset, address_reset};
			blocked_reg <= 1'b0;
		end else begin
			address_out_reg <= address_out_next;
			blocked_reg <= blocked_next;
		end
	end

	// ------------------------------------------------------------
	// Execution source and program counter redirect
	// ------------------------------------------------------------
	// The first cycle after reset picks the start memory. Afterwards a jump is served before a return:
	// the core never issues both at once, and a keyed jump must not lose its window to a stray return.
	always_comb begin
		boot_next = boot_reg;
		pc_load_next = 1'b0;
		pc_value_next = pc_value_reg;
		started_next = 1'b1;
		if (!started_reg) begin
			// RULE2: erased bit boots ROM
			// RULE3: programmed bit starts flash at 0000
			boot_next = !boot_select_bit_in;
			pc_load_next = 1'b1;
			pc_value_next = boot_select_bit_in ? flash_reset_vector : boot_rom_vector;
		end else if (jump_to_boot_instruction_in) begin
			pc_load_next = 1'b1;
			// RULE19: boot entry needs key
			if (key_flag) begin
				boot_next = 1'b1;
				pc_value_next = boot_rom_vector;
			// RULE20: no key, load jump target, execution source unchanged
			end else begin
				pc_value_next = jump_target_in;
			end
		end else if (return_to_flash_instruction_in && boot_reg) begin
			// RULE21: back to flash
			boot_next = 1'b0;
			pc_load_next = 1'b1;
			pc_value_next = return_target_in;
		end
	end

	// The boot-select bit is sampled after reset release, never inside reset.
	// Sampling it inside reset would let a slow nonvolatile read race the release.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			started_reg <= 1'b0;
			boot_reg <= 1'b1;
			pc_load_reg <= 1'b0;
			pc_value_reg <= 16'h0000;
		end else begin
			started_reg <= started_next;
			boot_reg <= boot_next;
			pc_load_reg <= pc_load_next;
			pc_value_reg <= pc_value_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Every output is a plain copy of a register, so the core never sees decode glitches.
	assign reg_rdata_out = rdata_reg;
	assign boot_rom_data_out = rom_data;
	assign exec_from_boot_out = boot_reg;
	assign pc_load_out = pc_load_reg;
	assign pc_value_out = pc_value_reg;
	assign flash_address_out = address_out_reg;
	assign flash_wdata_out = flash_write_data_reg;
	assign pulse_timing_out = write_pulse_timing_reg;
	assign flash_busy_out = busy_reg;
	assign fetch_blocked_out = blocked_reg;
	assign key_set_out = key_flag;
endmodule : isp_flash_access_boot_key

// >>> core/isp_access_pkg.sv
package isp_access_pkg;
	// ------------------------------------------------------------
	// Register selects on the core's register port
	// ------------------------------------------------------------
	localparam logic [2:0] sel_address_high = 3'h0;
	localparam logic [2:0] sel_address_low = 3'h1;
	localparam logic [2:0] sel_read_data = 3'h2;
	localparam logic [2:0] sel_write_data = 3'h3;
	localparam logic [2:0] sel_pulse_timing = 3'h4;
	localparam logic [2:0] sel_unlock = 3'h5;
	localparam logic [2:0] sel_control_internal = 3'h6;

	// ------------------------------------------------------------
	// Reset values and field layout
	// ------------------------------------------------------------
	localparam logic [7:0] address_reset = 8'h00;
	localparam logic [7:0] pulse_timing_reset = 8'h7b;
	localparam logic [7:0] pulse_timing_mask = 8'h7f;
	localparam logic [5:0] unlock_pattern = 6'h26;
	localparam int unlock_hi = 7;
	localparam int unlock_lo = 2;
	localparam logic [3:0] key_window_cycles = 4'h8;
	localparam logic [15:0] option_alias_address = 16'hffff;
	localparam logic [15:0] option_real_address = 16'h7fff;
	localparam logic [15:0] flash_reset_vector = 16'h0000;
	localparam logic [15:0] boot_rom_vector = 16'h0000;
	localparam int boot_rom_bytes = 1024;
	localparam int boot_rom_addr_bits = 10;

	typedef enum logic [1:0] {
		op_idle,
		op_read,
		op_write,
		op_erase
	} flash_op_type;
endpackage : isp_access_pkg

// >>> core/boot_rom_store.sv
`timescale 1ns/1ns
module boot_rom_store (
	input wire logic core_clk_in,
	input wire logic [isp_access_pkg::boot_rom_addr_bits-1:0] addr_in,
	output logic [7:0] data_out
);
	import isp_access_pkg::*;

	logic [7:0] rom_mem [0:boot_rom_bytes-1];
	logic [7:0] data_reg;

	// Contents are loaded at manufacture; simulation sees zero until then.
	initial begin
		for (int i = 0; i < boot_rom_bytes; i++) begin
			rom_mem[i] = 8'h00;
		end
	end

	always_ff @(posedge core_clk_in) begin
		data_reg <= rom_mem[addr_in];
	end

	assign data_out = data_reg;
endmodule : boot_rom_store

// >>> core/key_window_timer.sv
`timescale 1ns/1ns
module key_window_timer (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic load_in,
	input wire logic freeze_in,
	output logic key_set_out
);
	import isp_access_pkg::*;

	logic [3:0] count_reg;
	logic [3:0] count_next;
	logic key_reg;
	logic key_next;

	always_comb begin
		count_next = count_reg;
		// RULE24: restart the window
		if (load_in) begin
			count_next = key_window_cycles;
		// RULE22: freeze at breakpoint
		end else if (freeze_in) begin
			count_next = count_reg;
		// RULE23: keeps counting unless loaded or frozen
		end else if (count_reg != 4'h0) begin
			count_next = count_reg - 4'h1;
		end
		// RULE18: set for eight cycles
		key_next = (count_next != 4'h0);
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			count_reg <= 4'h0;
			key_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			key_reg <= key_next;
		end
	end

	assign key_set_out = key_reg;
endmodule : key_window_timer

// >>> tb/isp_flash_access_boot_key_properties.sv
`timescale 1ns/1ns
module isp_flash_access_boot_key_properties (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic reg_write_in,
	input wire logic [2:0] reg_select_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic boot_select_bit_in,
	input wire logic jump_to_boot_instruction_in,
	input wire logic [15:0] jump_target_in,
	input wire logic return_to_flash_instruction_in,
	input wire logic [15:0] return_target_in,
	input wire logic emulation_break_in,
	input wire logic [15:0] flash_address_out,
	input wire logic exec_from_boot_out,
	input wire logic pc_load_out,
	input wire logic [15:0] pc_value_out,
	input wire logic key_set_out
);
	import isp_access_pkg::*;
	// ----------------------------------------
	// Key window, branch, start memory and address relations
	// ----------------------------------------
	wire key_wr = reg_write_in && reg_select_in == sel_unlock;
	wire key_hit = key_wr && reg_wdata_in[7:2] == 6'h26;
	wire jmp = jump_to_boot_instruction_in;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	a_key_hold: assert property (key_hit |=> key_set_out [*8])
		else $error("key flag dropped inside its window");
	// Writes and breakpoints stay low so nothing may legally stretch the window.
	a_key_expire: assert property (key_hit ##1 (!reg_write_in && !emulation_break_in) [*8] |=> !key_set_out)
		else $error("key flag outlived its window");
	a_key_reject: assert property (key_wr && !key_hit && !key_set_out |=> !key_set_out)
		else $error("wrong key pattern set the flag");
	a_jump_boot: assert property (jmp && key_set_out |=> pc_load_out && exec_from_boot_out && pc_value_out == 16'h0000)
		else $error("keyed jump did not enter boot code");
	a_jump_flash: assert property (jmp && !key_set_out && !exec_from_boot_out
		|=> pc_load_out && !exec_from_boot_out && pc_value_out == $past(jump_target_in))
		else $error("unkeyed jump left flash target");
	a_return_flash: assert property (return_to_flash_instruction_in && !jmp && exec_from_boot_out
		|=> pc_load_out && !exec_from_boot_out && pc_value_out == $past(return_target_in))
		else $error("return did not reach flash target");
	a_boot_choice: assert property ($rose(resetn_in)
		|=> pc_load_out && pc_value_out == 16'h0000 && exec_from_boot_out != boot_select_bit_in)
		else $error("wrong start memory after reset");
	a_addr_low: assert property (reg_write_in && reg_select_in == sel_address_low
		|=> flash_address_out[7:0] == $past(reg_wdata_in))
		else $error("low address byte not on address bus");
endmodule : isp_flash_access_boot_key_properties

bind isp_flash_access_boot_key isp_flash_access_boot_key_properties u_props (
	.core_clk_in(core_clk_in), .resetn_in(resetn_in), .reg_write_in(reg_write_in),
	.reg_select_in(reg_select_in), .reg_wdata_in(reg_wdata_in), .boot_select_bit_in(boot_select_bit_in),
	.jump_to_boot_instruction_in(jump_to_boot_instruction_in), .jump_target_in(jump_target_in),
	.return_to_flash_instruction_in(return_to_flash_instruction_in), .return_target_in(return_target_in),
	.emulation_break_in(emulation_break_in), .flash_address_out(flash_address_out),
	.exec_from_boot_out(exec_from_boot_out), .pc_load_out(pc_load_out), .pc_value_out(pc_value_out),
	.key_set_out(key_set_out)
);

// >>> tb/flash_array_model.sv
`timescale 1ns/1ns
module flash_array_model (
	input wire logic core_clk_in,
	input wire logic busy_in,
	input wire logic [15:0] address_in,
	input wire logic [3:0] delay_in,
	output logic done_out = 1'b0,
	output logic [7:0] rdata_out = 8'h00
);
	// ----------------------------------------
	// Flash array answering one operation
	// ----------------------------------------
	logic [3:0] wait_reg = 4'h0;
	// Data toggles outside the done cycle, so a late capture reads garbage.
	always @(posedge core_clk_in) begin
		done_out <= 1'b0;
		rdata_out <= ~rdata_out;
		wait_reg <= 4'h0;
		if (busy_in && !done_out) begin
			if (wait_reg == delay_in) begin
				done_out <= 1'b1;
				rdata_out <= address_in[7:0] ^ 8'h5a;
			end else begin
				wait_reg <= wait_reg + 4'h1;
			end
		end
	end
endmodule : flash_array_model

// >>> tb/isp_flash_access_boot_key_tb_top.sv
`timescale 1ns/1ns
module isp_flash_access_boot_key_tb_top;
	import isp_access_pkg::*;
	// ----------------------------------------
	// Core side stimulus
	// ----------------------------------------
	logic clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, bsel = 1'b0, jmp = 1'b0, ret = 1'b0, brk = 1'b0;
	logic [2:0] sel = 3'h0;
	logic [7:0] wd = 8'h00;
	logic [1:0] op = 2'h0;
	logic [3:0] dly = 4'h5;
	logic [9:0] fetch = 10'h3ff;
	logic [15:0] jt = 16'h0200, rt = 16'h0100;
	logic done, exb, pcl, bsy, fbl, key;
	logic [7:0] frd, rdo, rom, fwd, pto;
	logic [15:0] fao, pcv;
	int fails = 0, n_compared = 0, i;
	isp_flash_access_boot_key dut (
		.core_clk_in(clk), .resetn_in(resetn), .reg_write_in(wr_en), .reg_read_in(rd_en),
		.reg_select_in(sel), .reg_wdata_in(wd), .boot_select_bit_in(bsel),
		.jump_to_boot_instruction_in(jmp), .jump_target_in(jt), .return_to_flash_instruction_in(ret),
		.return_target_in(rt), .emulation_break_in(brk), .flash_op_in(op), .flash_done_in(done),
		.flash_rdata_in(frd), .boot_fetch_addr_in(fetch), .reg_rdata_out(rdo), .boot_rom_data_out(rom),
		.exec_from_boot_out(exb), .pc_load_out(pcl), .pc_value_out(pcv), .flash_address_out(fao),
		.flash_wdata_out(fwd), .pulse_timing_out(pto), .flash_busy_out(bsy), .fetch_blocked_out(fbl),
		.key_set_out(key)
	);
	flash_array_model flash (.core_clk_in(clk), .busy_in(bsy), .address_in(fao), .delay_in(dly),
		.done_out(done), .rdata_out(frd));
	initial begin
		forever #20 clk = ~clk;
	end
	task print_verdict;
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [2:0] s, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		sel <= s;
		wd <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task rd(input logic [2:0] s, input logic [7:0] e);
		@(posedge clk);
		rd_en <= 1'b1;
		sel <= s;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk(16'(rdo), 16'(e));
	endtask : rd
	task strobe(input logic j, input logic r, input logic eb, input logic [15:0] epc);
		@(posedge clk);
		jmp <= j;
		ret <= r;
		@(posedge clk);
		jmp <= 1'b0;
		ret <= 1'b0;
		#1 chk(16'(pcl), 16'h0001);
		chk(16'(exb), 16'(eb));
		chk(pcv, epc);
	endtask : strobe
	task do_reset(input logic b);
		@(posedge clk);
		resetn <= 1'b0;
		bsel <= b;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1 chk(16'(exb), 16'(!b));
		chk(16'(pcl), 16'h0001);
		chk(pcv, 16'h0000);
	endtask : do_reset
	// Beyond eight cycles the breakpoint is held for four edges, from the second to the fifth.
	task key_run(input int n);
		for (i = 0; i < n; i++) begin
			#1 chk(16'(key), 16'h0001);
			@(posedge clk);
			brk <= (n > 8 && i < 4);
		end
		#1 chk(16'(key), 16'h0000);
	endtask : key_run
	task flash_op(input logic [1:0] o, input logic blk);
		@(posedge clk);
		op <= o;
		@(posedge clk);
		op <= 2'h0;
		#1 chk(16'(fbl), 16'(blk));
		for (i = 0; i < 20 && bsy === 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (bsy !== 1'b0) begin
			fails++;
			print_verdict;
		end
	endtask : flash_op
	initial begin
		do_reset(1'b0);
		rd(sel_address_high, 8'h00);
		rd(sel_address_low, 8'h00);
		chk(16'(rom), 16'h0000);
		rd(sel_pulse_timing, 8'h7b);
		wr(sel_address_high, 8'h12);
		wr(sel_address_low, 8'h34);
		#1 chk(fao, 16'h1234);
		rd(sel_address_high, 8'h12);
		wr(sel_pulse_timing, 8'hff);
		rd(sel_pulse_timing, 8'h7f);
		wr(sel_pulse_timing, 8'h01);
		#1 chk(16'(pto), 16'h0001);
		wr(sel_write_data, 8'ha5);
		rd(sel_write_data, 8'ha5);
		chk(16'(fwd), 16'h00a5);
		rd(sel_unlock, 8'h00);
		wr(sel_control_internal, 8'hff);
		rd(sel_control_internal, 8'h00);
		flash_op(2'h1, 1'b0);
		wr(sel_read_data, 8'h00);
		rd(sel_read_data, 8'h6e);
		dly <= 4'h0;
		flash_op(2'h2, 1'b1);
		wr(sel_address_high, 8'h00);
		wr(sel_address_low, 8'h00);
		flash_op(2'h3, 1'b1);
		wr(sel_address_high, 8'hff);
		wr(sel_address_low, 8'hff);
		#1 chk(fao, 16'h7fff);
		strobe(1'b0, 1'b1, 1'b0, 16'h0100);
		strobe(1'b1, 1'b0, 1'b0, 16'h0200);
		wr(sel_unlock, 8'h9c);
		#1 chk(16'(key), 16'h0000);
		wr(sel_unlock, 8'h9b);
		key_run(8);
		wr(sel_unlock, 8'h98);
		key_run(12);
		wr(sel_unlock, 8'h98);
		wr(sel_unlock, 8'h9a);
		key_run(8);
		wr(sel_unlock, 8'h99);
		strobe(1'b1, 1'b0, 1'b1, 16'h0000);
		do_reset(1'b1);
		print_verdict;
	end
endmodule : isp_flash_access_boot_key_tb_top
